// ### verilog/svp_pkg.sv
// Shared constants, types and speed ladder for the stepper timing block
package svp_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int REF_KHZ = 25000; // ref_clk rate
  localparam int OSC_KHZ = 4000; // Oscillator timebase, 4.0 MHz nominal
  localparam logic [14:0] OSC_INC = 15'(OSC_KHZ);
  localparam logic [14:0] OSC_MOD = 15'(REF_KHZ);

  // ----------------------------------------------------------------
  // Interval figures and derived tick counts
  // ----------------------------------------------------------------
  localparam int PWM_SLOW_HZ100 = 228; // 22.8 kHz in 100 Hz units
  localparam int PWM_FAST_HZ100 = 456; // 45.6 kHz in 100 Hz units
  localparam logic [8:0] PWM_SLOW_TICKS = 9'((OSC_KHZ * 10 + PWM_SLOW_HZ100 / 2) / PWM_SLOW_HZ100);
  localparam logic [8:0] PWM_FAST_TICKS = 9'((OSC_KHZ * 10 + PWM_FAST_HZ100 / 2) / PWM_FAST_HZ100);
  localparam int JIT_DEPTH_PCT = 10;
  localparam logic [5:0] PWM_SLOW_DEP = 6'(int'(PWM_SLOW_TICKS) * JIT_DEPTH_PCT / 100);
  localparam logic [5:0] PWM_FAST_DEP = 6'(int'(PWM_FAST_TICKS) * JIT_DEPTH_PCT / 100);
  localparam int SCAN_PERIOD_US = 1024;
  localparam int SCAN_ON_US = 128;
  localparam logic [12:0] SCAN_PERIOD_TICKS = 13'(SCAN_PERIOD_US * OSC_KHZ / 1000);
  localparam logic [12:0] SCAN_ON_TICKS = 13'(SCAN_ON_US * OSC_KHZ / 1000);
  localparam int STAB_MS = 32;
  localparam int STAB_TICKS = STAB_MS * OSC_KHZ;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] RATE_OFS = 8'h0c;
  localparam int CTRL_W = 10;
  localparam int STATUS_W = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HALF = 2'h0,
    MODE_QUARTER = 2'h1,
    MODE_EIGHTH = 2'h2,
    MODE_SIXTEENTH = 2'h3
  } svp_mode_t;

  typedef enum logic [1:0] {
    GRP_A = 2'h0,
    GRP_B = 2'h1,
    GRP_C = 2'h2,
    GRP_D = 2'h3
  } svp_group_t;

  typedef enum logic [2:0] {
    CUR_HOLD = 3'b001,
    CUR_STAB = 3'b010,
    CUR_SETTLED = 3'b100
  } svp_cur_t;

  typedef struct packed {
    logic run_current;
    logic motion_run;
    logic pwm_jitter_enable;
    logic pwm_rate_select;
    logic [3:0] vmax_idx;
    svp_mode_t step_mode;
  } svp_ctrl_t;

  typedef struct packed {
    logic hw_addr_seen;
    logic switch_seen;
    logic group_cross;
    logic settled;
    logic busy;
    svp_group_t group;
  } svp_status_t;

  localparam svp_ctrl_t CTRL_RST = svp_ctrl_t'(10'h000);

  // ----------------------------------------------------------------
  // Speed ladder: full, half, quarter, eighth, sixteenth step rates
  // ----------------------------------------------------------------
  localparam logic [15:0] SPEED_LADDER [16][5] = '{
    '{16'h0063, 16'h00c5, 16'h018b, 16'h0316, 16'h062b},
    '{16'h0088, 16'h0111, 16'h0222, 16'h0443, 16'h0886},
    '{16'h00a7, 16'h014e, 16'h029c, 16'h0537, 16'h0a6e},
    '{16'h00c5, 16'h018b, 16'h0316, 16'h062b, 16'h0c57},
    '{16'h00d5, 16'h01a9, 16'h0353, 16'h06a5, 16'h0d4b},
    '{16'h00e4, 16'h01c8, 16'h0390, 16'h071f, 16'h0e3f},
    '{16'h00f3, 16'h01e6, 16'h03cd, 16'h0799, 16'h0f33},
    '{16'h0111, 16'h0222, 16'h0443, 16'h0886, 16'h110c},
    '{16'h012f, 16'h025f, 16'h04bd, 16'h097a, 16'h12f4},
    '{16'h014e, 16'h029c, 16'h0537, 16'h0a6e, 16'h14dd},
    '{16'h016c, 16'h02d9, 16'h05b1, 16'h0b62, 16'h16c5},
    '{16'h018b, 16'h0316, 16'h062b, 16'h0c57, 16'h18ad},
    '{16'h01c8, 16'h0390, 16'h071f, 16'h0e3f, 16'h1c7e},
    '{16'h0222, 16'h0443, 16'h0886, 16'h110c, 16'h2218},
    '{16'h02d9, 16'h05b1, 16'h0b62, 16'h16c5, 16'h2d8a},
    '{16'h03cd, 16'h0799, 16'h0f33, 16'h1e66, 16'h3ccc}
  };
  localparam logic [3:0] GRP_B_FIRST = 4'h1;
  localparam logic [3:0] GRP_C_FIRST = 4'h7;
  localparam logic [3:0] GRP_D_FIRST = 4'hd;

  // Nearest whole tick count for one step at the given rate
  function automatic logic [15:0] ticks_of(logic [15:0] rate);
    return 16'((OSC_KHZ * 1000 + int'(rate) / 2) / int'(rate));
  endfunction

  // Compatibility group of a top-speed index
  function automatic svp_group_t group_of(logic [3:0] idx);
    if (idx < GRP_B_FIRST) begin
      return GRP_A;
    end else if (idx < GRP_C_FIRST) begin
      return GRP_B;
    end else if (idx < GRP_D_FIRST) begin
      return GRP_C;
    end
    return GRP_D;
  endfunction

endpackage

// ### verilog/svp_interval_timer.sv
// Oscillator-tick interval counter with a live period input
`timescale 1ns/1ps
module svp_interval_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic [W-1:0] period,
  // Status
  output logic [W-1:0] count,
  output logic wrap
);

  logic [W-1:0] cnt_q;
  logic at_end;

  // A shorter period takes hold at once: the compare is >=, not ==
  assign at_end = (cnt_q >= W'(period - W'(1)));
  assign wrap = enable && tick && at_end;
  assign count = cnt_q;

  // Count oscillator ticks, restart on wrap or when disabled
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= at_end ? '0 : W'(cnt_q + W'(1));
    end
  end

endmodule

// ### verilog/svp_speed_lookup.sv
// Top-speed index and step resolution decode to rate, period and group
`timescale 1ns/1ps
module svp_speed_lookup (
  // Selection
  input wire logic [3:0] vmax_idx,
  input wire svp_pkg::svp_mode_t step_mode,
  // Decoded speed
  output logic [15:0] step_ticks,
  output logic [15:0] step_rate,
  output logic [15:0] full_rate,
  output svp_pkg::svp_group_t group
);

  logic [15:0] tick_tab [16][4];
  logic [2:0] col;

  // Step periods fold to constants: each rate has its own rounded count
  for (genvar i = 0; i < 16; i++) begin : g_idx
    for (genvar j = 0; j < 4; j++) begin : g_mode
      assign tick_tab[i][j] = svp_pkg::ticks_of(svp_pkg::SPEED_LADDER[i][j+1]);
    end
  end

  // Column zero holds the full-step rate
  assign col = {1'b0, step_mode} + 3'h1;
  assign step_ticks = tick_tab[vmax_idx][step_mode];
  assign step_rate = svp_pkg::SPEED_LADDER[vmax_idx][col];
  assign full_rate = svp_pkg::SPEED_LADDER[vmax_idx][0];
  assign group = svp_pkg::group_of(vmax_idx);

endmodule

// ### verilog/svp_stepper_timing.sv
// Step rate, coil PWM, input scan and current settle timing with AHB-Lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module svp_stepper_timing #(
  parameter int STAB_TICKS = svp_pkg::STAB_TICKS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Sampled field inputs
  input wire logic motion_switch_input,
  input wire logic hardwired_address_input,
  // Timing outputs
  output logic step_pulse,
  output logic scan_pulse,
  output logic coil_outputs_pwm
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [14:0] osc_acc_q;
  logic [14:0] osc_sum;
  logic osc_tick_q;
  logic dp_valid_q;
  logic dp_write_q;
  logic dp_word_q;
  logic [7:0] dp_addr_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_stat;
  svp_pkg::svp_ctrl_t ctrl_q;
  svp_pkg::svp_ctrl_t ctrl_new;
  svp_pkg::svp_status_t status;
  svp_pkg::svp_status_t stat_new;
  svp_pkg::svp_group_t cur_group;
  logic [15:0] step_ticks;
  logic [15:0] step_rate;
  logic [15:0] full_rate;
  logic cross_evt;
  logic grp_cross_q;
  logic [15:0] step_cnt;
  logic step_wrap;
  logic step_pulse_q;
  logic [31:0] step_total_q;
  svp_pkg::svp_cur_t cur_q;
  logic [16:0] stab_cnt_q;
  logic [8:0] pwm_base;
  logic [5:0] pwm_dep;
  logic signed [6:0] jit_q;
  logic jit_up_q;
  logic [8:0] pwm_period;
  logic [8:0] pwm_cnt;
  logic pwm_wrap;
  logic coil_pwm_q;
  logic [12:0] scan_cnt;
  logic scan_pulse_q;
  logic switch_seen_q;
  logic hw_addr_seen_q;

  // ----------------------------------------------------------------
  // Oscillator timebase
  // ----------------------------------------------------------------
  // Fractional divider: 4 ticks per 25 ref cycles, spacing 6 or 7
  assign osc_sum = 15'(osc_acc_q + svp_pkg::OSC_INC);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_acc_q <= '0;
      osc_tick_q <= 1'b0;
    end else if (osc_sum >= svp_pkg::OSC_MOD) begin
      osc_acc_q <= 15'(osc_sum - svp_pkg::OSC_MOD);
      osc_tick_q <= 1'b1;
    end else begin
      osc_acc_q <= osc_sum;
      osc_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;
  // Reads take one wait state so they see any write just before them
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_ctrl = dp_valid_q && dp_write_q && dp_word_q && (dp_addr_q == svp_pkg::CTRL_OFS);
  assign wr_stat = dp_valid_q && dp_write_q && dp_word_q && (dp_addr_q == svp_pkg::STATUS_OFS);

  // Address phase capture
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_word_q <= 1'b0;
      dp_addr_q <= '0;
    end else if (hready) begin
      dp_valid_q <= addr_ok;
      dp_write_q <= hwrite;
      dp_word_q <= (hsize == 3'h2);
      dp_addr_q <= haddr[7:0];
    end
  end

  // Read wait state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= addr_ok && !hwrite;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hrdata_q <= '0;
    end else if (rd_wait_q) begin
      case (dp_addr_q)
        svp_pkg::CTRL_OFS: hrdata_q <= 32'(ctrl_q);
        svp_pkg::STATUS_OFS: hrdata_q <= 32'(status);
        svp_pkg::COUNT_OFS: hrdata_q <= step_total_q;
        svp_pkg::RATE_OFS: hrdata_q <= {full_rate, step_rate};
        default: hrdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  assign ctrl_new = svp_pkg::svp_ctrl_t'(hwdata[svp_pkg::CTRL_W-1:0]);
  // Status write data viewed through the field layout, for the clear bit
  assign stat_new = svp_pkg::svp_status_t'(hwdata[svp_pkg::STATUS_W-1:0]);

  // Control register; a speed write takes effect mid-motion
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= svp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_new;
    end
  end

  svp_speed_lookup u_speed (
    .vmax_idx(ctrl_q.vmax_idx),
    .step_mode(ctrl_q.step_mode),
    .step_ticks(step_ticks),
    .step_rate(step_rate),
    .full_rate(full_rate),
    .group(cur_group)
  );

  // Crossing groups while running is flagged, since steps may be lost
  assign cross_evt = wr_ctrl && ctrl_q.motion_run && ctrl_new.motion_run &&
    (svp_pkg::group_of(ctrl_new.vmax_idx) != cur_group);

  // Sticky flag, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      grp_cross_q <= 1'b0;
    end else if (cross_evt) begin
      grp_cross_q <= 1'b1;
    end else if (wr_stat && stat_new.group_cross) begin
      grp_cross_q <= 1'b0;
    end
  end

  assign status = '{
    hw_addr_seen: hw_addr_seen_q,
    switch_seen: switch_seen_q,
    group_cross: grp_cross_q,
    settled: (cur_q == svp_pkg::CUR_SETTLED),
    busy: ctrl_q.motion_run,
    group: cur_group
  };

  // ----------------------------------------------------------------
  // Step generator
  // ----------------------------------------------------------------
  svp_interval_timer #(
    .W(16)
  ) u_step_tmr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(osc_tick_q),
    .enable(ctrl_q.motion_run),
    .period(step_ticks),
    .count(step_cnt),
    .wrap(step_wrap)
  );

  // One pulse per step period; totals wrap silently at 2^32
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      step_pulse_q <= 1'b0;
      step_total_q <= '0;
    end else begin
      step_pulse_q <= step_wrap;
      if (step_wrap) begin
        step_total_q <= 32'(step_total_q + 32'h1);
      end
    end
  end

  assign step_pulse = step_pulse_q;

  // ----------------------------------------------------------------
  // Run current stabilisation
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_q <= svp_pkg::CUR_HOLD;
      stab_cnt_q <= '0;
    end else begin
      case (cur_q)
        svp_pkg::CUR_HOLD: begin
          stab_cnt_q <= '0;
          if (ctrl_q.run_current) begin
            cur_q <= svp_pkg::CUR_STAB;
          end
        end
        svp_pkg::CUR_STAB: begin
          if (!ctrl_q.run_current) begin
            cur_q <= svp_pkg::CUR_HOLD;
          end else if (osc_tick_q) begin
            if (stab_cnt_q == 17'(STAB_TICKS - 1)) begin
              cur_q <= svp_pkg::CUR_SETTLED;
            end else begin
              stab_cnt_q <= 17'(stab_cnt_q + 17'h1);
            end
          end
        end
        svp_pkg::CUR_SETTLED: begin
          if (!ctrl_q.run_current) begin
            cur_q <= svp_pkg::CUR_HOLD;
          end
        end
        default: cur_q <= svp_pkg::CUR_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Coil PWM carrier
  // ----------------------------------------------------------------
  assign pwm_base = ctrl_q.pwm_rate_select ? svp_pkg::PWM_FAST_TICKS : svp_pkg::PWM_SLOW_TICKS;
  assign pwm_dep = ctrl_q.pwm_rate_select ? svp_pkg::PWM_FAST_DEP : svp_pkg::PWM_SLOW_DEP;
  // Offset is masked off at once when jitter is disabled
  assign pwm_period = ctrl_q.pwm_jitter_enable ? 9'(pwm_base + 9'(unsigned'(9'(jit_q)))) : pwm_base;

  // Triangle sweep of the period offset, one step per PWM period
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      jit_q <= '0;
      jit_up_q <= 1'b1;
    end else if (!ctrl_q.pwm_jitter_enable) begin
      jit_q <= '0;
      jit_up_q <= 1'b1;
    end else if (pwm_wrap) begin
      if (jit_up_q && (jit_q >= $signed({1'b0, pwm_dep}))) begin
        jit_up_q <= 1'b0;
        jit_q <= 7'(jit_q - 7'sd1);
      end else if (!jit_up_q && (jit_q <= -$signed({1'b0, pwm_dep}))) begin
        jit_up_q <= 1'b1;
        jit_q <= 7'(jit_q + 7'sd1);
      end else begin
        jit_q <= jit_up_q ? 7'(jit_q + 7'sd1) : 7'(jit_q - 7'sd1);
      end
    end
  end

  svp_interval_timer #(
    .W(9)
  ) u_pwm_tmr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(osc_tick_q),
    .enable(1'b1),
    .period(pwm_period),
    .count(pwm_cnt),
    .wrap(pwm_wrap)
  );

  // Half-period high carrier
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      coil_pwm_q <= 1'b0;
    end else begin
      coil_pwm_q <= (pwm_cnt < (pwm_period >> 1));
    end
  end

  assign coil_outputs_pwm = coil_pwm_q;

  // ----------------------------------------------------------------
  // Input scan
  // ----------------------------------------------------------------
  svp_interval_timer #(
    .W(13)
  ) u_scan_tmr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(osc_tick_q),
    .enable(1'b1),
    .period(svp_pkg::SCAN_PERIOD_TICKS),
    .count(scan_cnt),
    .wrap()
  );

  // Inputs are caught at the last tick of each pulse, once settled
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_pulse_q <= 1'b0;
      switch_seen_q <= 1'b0;
      hw_addr_seen_q <= 1'b0;
    end else begin
      scan_pulse_q <= (scan_cnt < svp_pkg::SCAN_ON_TICKS);
      if (osc_tick_q && (scan_cnt == 13'(svp_pkg::SCAN_ON_TICKS - 13'h1))) begin
        switch_seen_q <= motion_switch_input;
        hw_addr_seen_q <= hardwired_address_input;
      end
    end
  end

  assign scan_pulse = scan_pulse_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_osc_spacing;
    osc_tick_q |=> !osc_tick_q [*5];
  endproperty
  a_osc_spacing: assert property (p_osc_spacing) else $error("oscillator ticks too close");

  property p_osc_due;
    osc_tick_q |-> ##[6:7] osc_tick_q;
  endproperty
  a_osc_due: assert property (p_osc_due) else $error("oscillator tick late");

  property p_half_rate;
    (ctrl_q.step_mode == svp_pkg::MODE_HALF && ctrl_q.vmax_idx == 4'h0) |-> step_rate == 16'h00c5;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half step rate wrong");

  property p_ladder_ends;
    (ctrl_q.vmax_idx == 4'h0 |-> full_rate == 16'h0063) and (ctrl_q.vmax_idx == 4'hf |-> full_rate == 16'h03cd);
  endproperty
  a_ladder_ends: assert property (p_ladder_ends) else $error("speed ladder end wrong");

  property p_top_rate;
    (ctrl_q.vmax_idx == 4'hf && ctrl_q.step_mode == svp_pkg::MODE_SIXTEENTH) |-> step_rate == 16'h3ccc;
  endproperty
  a_top_rate: assert property (p_top_rate) else $error("top micro-step rate wrong");

  property p_group_map;
    (ctrl_q.vmax_idx == 4'h6 |-> cur_group == svp_pkg::GRP_B) and (ctrl_q.vmax_idx == 4'hd |-> cur_group == svp_pkg::GRP_D);
  endproperty
  a_group_map: assert property (p_group_map) else $error("group boundary wrong");

  property p_cross_flag;
    cross_evt |=> grp_cross_q [*2];
  endproperty
  a_cross_flag: assert property (p_cross_flag) else $error("group crossing not held");

  property p_live_speed;
    (ctrl_q.motion_run && osc_tick_q) |=> step_cnt < $past(step_ticks);
  endproperty
  a_live_speed: assert property (p_live_speed) else $error("step count beyond period");

  property p_step_gap;
    step_pulse_q |=> !step_pulse_q [*8];
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("step pulses too close");

  property p_pwm_select;
    pwm_base == (ctrl_q.pwm_rate_select ? 9'h058 : 9'h0af);
  endproperty
  a_pwm_select: assert property (p_pwm_select) else $error("pwm base period wrong");

  property p_pwm_fixed;
    !ctrl_q.pwm_jitter_enable |-> pwm_period == pwm_base;
  endproperty
  a_pwm_fixed: assert property (p_pwm_fixed) else $error("pwm period moved without jitter");

  property p_scan_width;
    scan_pulse_q |-> $past(scan_cnt) < 13'h200;
  endproperty
  a_scan_width: assert property (p_scan_width) else $error("scan pulse too long");

  property p_stab_hold;
    $rose(ctrl_q.run_current) |=> (cur_q != svp_pkg::CUR_SETTLED) [*8];
  endproperty
  a_stab_hold: assert property (p_stab_hold) else $error("current settled too early");

  property p_settle_at;
    $rose(cur_q == svp_pkg::CUR_SETTLED) |-> $past(stab_cnt_q) == 17'(STAB_TICKS - 1);
  endproperty
  a_settle_at: assert property (p_settle_at) else $error("settle count wrong");

  c_step: cover property (step_pulse_q);
  c_cross: cover property ($rose(grp_cross_q));
  c_settled: cover property ($rose(cur_q == svp_pkg::CUR_SETTLED));
  c_jitter: cover property (ctrl_q.pwm_jitter_enable && jit_q != 7'sd0);

endmodule

// ### verification/svp_motor_model.sv
// Motor-side model: counts step pulses, times their spacing, answers input scans
`timescale 1ns/1ps
module svp_motor_model (
  // Clock
  input wire logic ref_clk,
  // From the block
  input wire logic step_pulse,
  input wire logic scan_pulse,
  // Levels chosen by the bench
  input wire logic sw_level,
  input wire logic addr_level,
  // To the block
  output logic motion_switch_input,
  output logic hardwired_address_input,
  // Observations
  output int step_n,
  output int step_gap
);
  int cyc = 0;
  int last = 0;
  logic scan_d = 1'b0;
  initial begin
    step_n = 0;
    step_gap = 0;
  end
  // Lines only hold their level around a scan; otherwise they invert, so early sampling shows
  always_comb begin
    motion_switch_input = (scan_pulse | scan_d) ? sw_level : !sw_level;
    hardwired_address_input = (scan_pulse | scan_d) ? addr_level : !addr_level;
  end
  // Step count and the cycles between steps
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    scan_d <= scan_pulse;
    if (step_pulse === 1'b1) begin
      step_n <= step_n + 1;
      step_gap <= cyc - last;
      last <= cyc;
    end
  end
endmodule

// ### verification/svp_stepper_timing_tb_top.sv
// Self-checking bench for the stepper timing block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module svp_stepper_timing_tb_top;
  // ------------------------------------------------------------
  // Signals, tables and design
  // ------------------------------------------------------------
  logic ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sw_level = 1'b0, addr_level = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h39;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, step_pulse, scan_pulse, pwm, msi, hai, pwm_d = 1'b0, scan_d = 1'b0;
  int miscompares = 0, n_checks = 0, cyc = 0, step_n, step_gap, pwm_gap, pwm_t, scan_t, scan_on, scan_gap, mn, mx;
  int full[16] = '{99, 136, 167, 197, 213, 228, 243, 273, 303, 334, 364, 395, 456, 546, 729, 973};
  // Step rate at index i in mode i mod 4
  int rate[16] = '{197, 546, 1335, 3159, 425, 912, 1945, 4364, 607, 1335, 2914, 6317, 912, 2182, 5829, 15564};
  always #20 ref_clk = !ref_clk;
  svp_stepper_timing #(.STAB_TICKS(20)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .motion_switch_input(msi), .hardwired_address_input(hai),
    .step_pulse(step_pulse), .scan_pulse(scan_pulse), .coil_outputs_pwm(pwm));
  svp_motor_model motor (.ref_clk(ref_clk), .step_pulse(step_pulse), .scan_pulse(scan_pulse), .sw_level(sw_level),
    .addr_level(addr_level), .motion_switch_input(msi), .hardwired_address_input(hai), .step_n(step_n),
    .step_gap(step_gap));
  // Edge timing of the PWM carrier and the scan pulse
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pwm_d <= pwm;
    scan_d <= scan_pulse;
    if (pwm & !pwm_d) begin
      pwm_gap <= cyc - pwm_t;
      pwm_t <= cyc;
    end
    if (scan_pulse & !scan_d) begin
      scan_gap <= cyc - scan_t;
      scan_t <= cyc;
    end
    if (!scan_pulse & scan_d) scan_on <= cyc - scan_t;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Cycles for a whole tick count at 25 ref cycles per 4 ticks; quantising allows one cycle either way
  function automatic int stepc(int r);
    return ((4000000 + r / 2) / r) * 25 / 4;
  endfunction
  function automatic int pwmc(int hz100);
    return ((40000 + hz100 / 2) / hz100) * 25 / 4;
  endfunction
  task automatic near(int g, int e);
    `CHK((g + 1 >= e && g <= e + 1), 1'b1)
  endtask
  // One AHB-Lite single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && k < 99) begin
      @(posedge ref_clk);
      k++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && k < 99) begin
      @(posedge ref_clk);
      k++;
    end
    rd = hrdata;
    if (k >= 99) miscompares++;
  endtask
  task automatic steps(int n);
    int s, k;
    s = step_n;
    k = 0;
    while (step_n < s + n && k < 30000) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    results();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    seed = xs(seed);
    sys_rst <= 1'b0;
    sw_level <= seed[0];
    addr_level <= seed[1];
    ahb(1'b1, 8'h10, seed);
    ahb(1'b0, 8'h10, 32'h0); `CHK(rd, 32'h0)
    ahb(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h0)
    // Every index, each at resolution i mod 4: rate, full rate and group
    for (int i = 0; i < 16; i++) begin
      ahb(1'b1, 8'h00, 32'(i * 4 + i % 4));
      ahb(1'b0, 8'h0c, 32'h0);
      `CHK(rd[15:0], 16'(rate[i]))
      `CHK(rd[31:16], 16'(full[i]))
      `CHK(hresp, 1'b0)
      ahb(1'b0, 8'h04, 32'h0);
      `CHK(rd[1:0], 2'(i == 0 ? 0 : i < 7 ? 1 : i < 13 ? 2 : 3))
    end
    // Run fast, then change speed mid-motion inside and across groups
    ahb(1'b1, 8'h00, {seed[31:10], 10'h13f});
    ahb(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h13f)
    steps(3); near(step_gap, stepc(15564));
    ahb(1'b1, 8'h00, 32'h137);
    steps(2); near(step_gap, stepc(8728));
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[4:2], 3'b001)
    ahb(1'b1, 8'h00, 32'h11f);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[4], 1'b1)
    steps(2); near(step_gap, stepc(4364));
    ahb(1'b1, 8'h04, 32'h10);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[4], 1'b0)
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b0, 8'h08, 32'h0); `CHK(rd, 32'(step_n))
    // PWM rates, then jitter on and off
    repeat (3000) @(posedge ref_clk);
    near(pwm_gap, pwmc(228));
    ahb(1'b1, 8'h00, 32'h40);
    repeat (2000) @(posedge ref_clk);
    near(pwm_gap, pwmc(456));
    ahb(1'b1, 8'h00, 32'hc0);
    mn = 99999;
    mx = 0;
    repeat (16) begin
      repeat (600) @(posedge ref_clk);
      mn = (pwm_gap < mn) ? pwm_gap : mn;
      mx = (pwm_gap > mx) ? pwm_gap : mx;
    end
    `CHK((mn >= pwmc(456) - 52 && mx <= pwmc(456) + 52 && mx - mn > 12), 1'b1)
    ahb(1'b1, 8'h00, 32'h40);
    repeat (1200) @(posedge ref_clk);
    near(pwm_gap, pwmc(456));
    // Run current settle with a shortened count of 20 ticks
    ahb(1'b1, 8'h00, 32'h200);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[3], 1'b0)
    repeat (100) @(posedge ref_clk);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[3], 1'b0)
    repeat (40) @(posedge ref_clk);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[3], 1'b1)
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[3], 1'b0)
    // Scan timing and the sampled input levels
    while (cyc < 60000) @(posedge ref_clk);
    near(scan_on, 3200);
    near(scan_gap, 25600);
    ahb(1'b0, 8'h04, 32'h0); `CHK(rd[6:5], {addr_level, sw_level})
    results();
  end
endmodule
